//--- core/dtcr_top.sv
// dual timer with toggle latch and capture/reload register
`timescale 1ns/1ps
`default_nettype none
module dtcr_top (
    // clock, reset, enable
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // configuration
    input  wire dtcr_pkg::dtcr_tcfg_s       aux_cfg,
    input  wire dtcr_pkg::dtcr_tcfg_s       core_cfg,
    input  wire dtcr_pkg::dtcr_ccfg_s       cap_cfg,
    // asynchronous pins
    input  wire dtcr_pkg::dtcr_pins_s       pins,
    // toggle latch pin
    output logic                            toggle_latch_output_pin,
    output logic                            toggle_latch_output_oe,
    // capture/compare unit clock
    output logic                            core_wrap_pulse,
    // status
    output logic [dtcr_pkg::TMR_W-1:0]      aux_timer,
    output logic [dtcr_pkg::TMR_W-1:0]      core_timer,
    output logic [dtcr_pkg::TMR_W-1:0]      capture_reload_reg,
    output logic                            core_toggle_latch,
    output logic                            capture_pulse
);
    import dtcr_pkg::*;

    // whole state of the top
    typedef struct packed {
        dtcr_pins_s       s1;     // first synchroniser stage
        dtcr_pins_s       s2;     // second synchroniser stage
        dtcr_pins_s       s3;     // previous value for edge detection
        logic [DIV_W-1:0] div;    // shared prescaler counter
        logic             tgl;    // core toggle latch
        logic             tgl_p;  // toggle latch last cycle
        logic [TMR_W-1:0] cap;    // capture/reload register
        logic             wrap_p; // registered core wrap
        logic             cap_p;  // registered capture event
    } dtcr_st_s;

    dtcr_st_s         st_q;       // registered state
    dtcr_st_s         st_d;       // next state
    logic             aux_tick;   // aux count enable
    logic             core_tick;  // core count enable
    logic             aux_down;   // aux direction
    logic             core_down;  // core direction
    logic             core_wrap;  // core wrap this cycle
    logic             aux_wrap;   // unused aux wrap
    logic             cap_evt;    // capture event this cycle
    logic             aux_clr;    // clear aux after capture
    logic             core_load;  // reload core
    logic [TMR_W-1:0] aux_cnt;    // aux count
    logic [TMR_W-1:0] core_cnt;   // core count

    // edge detect on a synchronised pair, per enabled polarity
    function automatic logic edge_hit(input logic cur, input logic prv,
                                      input dtcr_edge_s sel);
        edge_hit = (sel.rise & cur & ~prv) | (sel.fall & ~cur & prv);
    endfunction : edge_hit

    // prescaler tick: 2^(pre+1) clocks, never below two
    function automatic logic pre_hit(input logic [DIV_W-1:0] d,
                                     input logic [PRE_W-1:0] p);
        logic [DIV_W-1:0] m;
        m = DIV_W'((1 << (32'(p) + BASE_SHIFT)) - 1);
        pre_hit = ((d & m) == m);
    endfunction : pre_hit

    // count enable for one timer from its chosen source
    function automatic logic tick_of(input dtcr_tcfg_s c,
                                     input logic pre_t,
                                     input logic ext_t,
                                     input logic tgl_t);
        logic t;
        t = 1'b0;
        case (c.src)
            DTCR_SRC_PRE: t = pre_t;
            DTCR_SRC_EXT: t = ext_t;
            DTCR_SRC_TGL: t = tgl_t;
            default:      t = 1'b0;
        endcase
        tick_of = c.run & t;
    endfunction : tick_of

    // count enables, directions and capture decisions
    always_comb begin
        aux_tick  = tick_of(aux_cfg, pre_hit(st_q.div, aux_cfg.pre),
                        edge_hit(st_q.s2.aux_cnt, st_q.s3.aux_cnt,
                                 aux_cfg.ext_edge),
                        st_q.tgl ^ st_q.tgl_p);
        // core never counts its own latch; that source reads as stopped
        core_tick = tick_of(core_cfg, pre_hit(st_q.div, core_cfg.pre),
                        edge_hit(st_q.s2.core_cnt, st_q.s3.core_cnt,
                                 core_cfg.ext_edge),
                        1'b0);
        // pin direction: high means count down
        aux_down  = aux_cfg.dir_pin_en ? st_q.s2.aux_dir
                                       : aux_cfg.down;
        core_down = core_cfg.dir_pin_en ? st_q.s2.core_dir
                                        : core_cfg.down;
        cap_evt   = edge_hit(st_q.s2.capture_input_pin, st_q.s3.capture_input_pin,
                             cap_cfg.capture_input_pin_edge)
                  | edge_hit(st_q.s2.comp_in, st_q.s3.comp_in,
                             cap_cfg.comp_in_edge)
                  | edge_hit(st_q.s2.comp_dir, st_q.s3.comp_dir,
                             cap_cfg.comp_dir_edge);
        aux_clr   = cap_evt & cap_cfg.clr_aux;
        core_load = core_wrap & cap_cfg.reload_en;
    end

    // next state of synchronisers, prescaler, latch and capture register
    always_comb begin
        st_d        = st_q;
        st_d.s1     = pins;
        st_d.s2     = st_q.s1;
        st_d.s3     = st_q.s2;
        st_d.div    = st_q.div + 10'h001;
        st_d.tgl_p  = st_q.tgl;
        st_d.wrap_p = core_wrap;
        st_d.cap_p  = cap_evt;
        if (core_wrap) begin
            st_d.tgl = ~st_q.tgl;
        end
        // capture takes the count before any clear lands
        if (cap_evt) begin
            st_d.cap = aux_cnt;
        end
    end

    // state register; enable low freezes everything
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q.s1     <= '0;
            st_q.s2     <= '0;
            st_q.s3     <= '0;
            st_q.div    <= DIV_RST;
            st_q.tgl    <= 1'b0;
            st_q.tgl_p  <= 1'b0;
            st_q.cap    <= TMR_RST;
            st_q.wrap_p <= 1'b0;
            st_q.cap_p  <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // auxiliary timer, cleared to zero after capture
    dtcr_timer u_aux (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .ce       (ce),
        .tick     (aux_tick),
        .down     (aux_down),
        .load     (aux_clr),
        .load_val (TMR_RST),
        .count    (aux_cnt),
        .wrap     (aux_wrap)
    );

    // core timer, reloaded from the capture register on wrap
    dtcr_timer u_core (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .ce       (ce),
        .tick     (core_tick),
        .down     (core_down),
        .load     (core_load),
        .load_val (st_q.cap),
        .count    (core_cnt),
        .wrap     (core_wrap)
    );

    // outputs; latch pin only driven when enabled
    assign toggle_latch_output_pin = st_q.tgl & cap_cfg.tgl_out_en;
    assign toggle_latch_output_oe  = cap_cfg.tgl_out_en;
    assign core_wrap_pulse         = st_q.wrap_p;
    assign aux_timer               = aux_cnt;
    assign core_timer              = core_cnt;
    assign capture_reload_reg      = st_q.cap;
    assign core_toggle_latch       = st_q.tgl;
    assign capture_pulse           = st_q.cap_p;
endmodule : dtcr_top
`default_nettype wire

//--- core/dtcr_pkg.sv
// package of constants and carrier types for the dual timer block
package dtcr_pkg;
    localparam int TMR_W            = 16;           // timer width
    localparam int PRE_W            = 3;            // prescaler select width
    localparam int DIV_W            = 10;           // prescaler counter width
    localparam logic [15:0] TMR_RST = 16'h0000;     // timer reset value
    localparam logic [15:0] TMR_MAX = 16'hFFFF;     // all-ones count
    localparam int MIN_TICK_CYC     = 2;            // finest resolution
    localparam int BASE_SHIFT       = 1;            // log2 of MIN_TICK_CYC
    localparam logic [9:0] DIV_RST  = 10'h000;      // prescaler reset value

    // count clock sources
    typedef enum logic [2:0] {
        DTCR_SRC_PRE = 3'b001,    // prescaled system clock
        DTCR_SRC_EXT = 3'b010,    // external input edges
        DTCR_SRC_TGL = 3'b100     // core toggle latch edges (aux only)
    } dtcr_src_e;

    // edge select for external events
    typedef struct packed {
        logic rise;               // trigger on rising edge
        logic fall;               // trigger on falling edge
    } dtcr_edge_s;

    // per-timer configuration
    typedef struct packed {
        logic             run;          // timer runs
        dtcr_src_e        src;          // count clock source
        logic [PRE_W-1:0] pre;          // prescale 2^(pre+1) clocks
        dtcr_edge_s       ext_edge;     // external count edge select
        logic             dir_pin_en;   // direction from pin
        logic             down;         // software direction: 1 = down
    } dtcr_tcfg_s;

    // capture/reload configuration
    typedef struct packed {
        dtcr_edge_s capture_input_pin_edge;   // capture pin edges
        dtcr_edge_s comp_in_edge; // companion count input edges
        dtcr_edge_s comp_dir_edge;// companion direction input edges
        logic       clr_aux;      // clear aux timer after capture
        logic       reload_en;    // reload core on wrap
        logic       tgl_out_en;   // drive toggle latch to pin
    } dtcr_ccfg_s;

    // synchronised pin inputs
    typedef struct packed {
        logic aux_cnt;            // aux count input
        logic aux_dir;            // aux direction input
        logic core_cnt;           // core count input
        logic core_dir;           // core direction input
        logic capture_input_pin;              // capture input
        logic comp_in;            // companion count input
        logic comp_dir;           // companion direction input
    } dtcr_pins_s;
endpackage : dtcr_pkg

//--- core/dtcr_timer.sv
// one sixteen bit up/down timer with wrap detection
`timescale 1ns/1ps
`default_nettype none
module dtcr_timer (
    // clock, reset and enable
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // control
    input  wire logic                       tick,
    input  wire logic                       down,
    input  wire logic                       load,
    input  wire logic [dtcr_pkg::TMR_W-1:0] load_val,
    // status
    output logic [dtcr_pkg::TMR_W-1:0]      count,
    output logic                            wrap
);
    import dtcr_pkg::*;

    // whole state of the timer
    typedef struct packed {
        logic [TMR_W-1:0] cnt;    // count value
    } dtcr_tst_s;

    dtcr_tst_s st_q;              // registered state
    dtcr_tst_s st_d;              // next state
    logic      wrap_c;            // combinational wrap

    // next count; a load wins over a tick in the same cycle
    always_comb begin
        st_d   = st_q;
        wrap_c = 1'b0;
        if (tick) begin
            wrap_c = down ? (st_q.cnt == TMR_RST)
                          : (st_q.cnt == TMR_MAX);
            st_d.cnt = down ? st_q.cnt - 16'h0001 : st_q.cnt + 16'h0001;
        end
        if (load) begin
            st_d.cnt = load_val;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q.cnt <= TMR_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
    assign wrap  = wrap_c;
endmodule : dtcr_timer
`default_nettype wire

//--- verification/dtcr_pin_drv.sv
// external pin sources for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtcr_pin_drv (
    // clock
    input  wire logic                clk_sys,
    // pin levels
    output var dtcr_pkg::dtcr_pins_s pins
);
    logic [6:0] lv_q = 7'h00; // levels, held between flips
    assign pins = lv_q;
    // flip one pin after a falling edge, then hold it past the sync
    task automatic flip(input int idx);
        @(negedge clk_sys);
        lv_q[idx] = ~lv_q[idx];
        repeat (4) @(negedge clk_sys);
    endtask : flip
endmodule : dtcr_pin_drv
`default_nettype wire

//--- verification/dtcr_top_sva.sv
// checker for the dual timer block ports
`timescale 1ns/1ps
`default_nettype none
module dtcr_top_sva (
    // clock and control
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    input wire logic                 ce,
    input wire dtcr_pkg::dtcr_tcfg_s core_cfg,
    input wire dtcr_pkg::dtcr_ccfg_s cap_cfg,
    // outputs
    input wire logic                 toggle_latch_output_pin,
    input wire logic                 toggle_latch_output_oe,
    input wire logic                 core_wrap_pulse,
    input wire logic [15:0]          aux_timer,
    input wire logic [15:0]          core_timer,
    input wire logic [15:0]          capture_reload_reg,
    input wire logic                 core_toggle_latch,
    input wire logic                 capture_pulse
);
    import dtcr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // wrap steps: latch flip and a one-cycle pulse, both on the same edge
    sequence s_flip; $changed(core_toggle_latch); endsequence
    sequence s_pulse; core_wrap_pulse ##1 !core_wrap_pulse; endsequence
    // latch flip and pulse rise land on the same edge
    a_flip_then_pulse: assert property (s_flip |-> s_pulse)
        else $error("no wrap pulse after latch flip");
    a_pulse_cause: assert property (core_wrap_pulse |->
        core_toggle_latch != $past(core_toggle_latch))
        else $error("wrap pulse without latch flip");
    a_wrap_value: assert property (core_wrap_pulse && !cap_cfg.reload_en
        |-> $past(core_timer) inside {16'h0000, 16'hFFFF})
        else $error("wrap left wrong count");
    a_reload_load: assert property (core_wrap_pulse && cap_cfg.reload_en
        && !$past(capture_pulse)
        |-> core_timer == $past(capture_reload_reg))
        else $error("reload value wrong");
    a_tick_space: assert property ($changed(core_timer)
        |=> $stable(core_timer))
        else $error("core ticks closer than two cycles");
    a_cap_copy: assert property (capture_pulse
        |-> capture_reload_reg == $past(aux_timer))
        else $error("capture value wrong");
    a_aux_clear: assert property (capture_pulse && cap_cfg.clr_aux
        |-> aux_timer == 16'h0000)
        else $error("aux not cleared after capture");
    a_pin_gate: assert property (toggle_latch_output_oe
        == cap_cfg.tgl_out_en && toggle_latch_output_pin
        == (core_toggle_latch & cap_cfg.tgl_out_en))
        else $error("latch pin gating wrong");
    a_stop_hold: assert property (!core_cfg.run || !ce
        |=> $stable(core_timer))
        else $error("core moved while stopped");
endmodule : dtcr_top_sva
bind dtcr_top dtcr_top_sva u_dtcr_top_sva (.clk_sys, .rstn, .ce,
    .core_cfg, .cap_cfg, .toggle_latch_output_pin,
    .toggle_latch_output_oe, .core_wrap_pulse, .aux_timer, .core_timer,
    .capture_reload_reg, .core_toggle_latch, .capture_pulse);
`default_nettype wire

//--- verification/dtcr_top_bench.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtcr_top_bench;
    import dtcr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    dtcr_tcfg_s  aux_cfg = '0;
    dtcr_tcfg_s  core_cfg = '0;
    dtcr_ccfg_s  cap_cfg = '0;
    dtcr_pins_s  pins;
    logic        pin_o, pin_oe, wrap_p, latch, cap_p;
    logic [15:0] aux_t, core_t, cap_r;
    int          miscompares = 0;
    int          check_count = 0;
    int          caps = 0;  // capture pulses seen
    always #4 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (cap_p === 1'b1) caps++;
    dtcr_pin_drv u_dtcr_pin_drv (.clk_sys, .pins);
    dtcr_top u_dtcr_top (.clk_sys, .rstn, .ce, .aux_cfg, .core_cfg,
        .cap_cfg, .pins, .toggle_latch_output_pin(pin_o),
        .toggle_latch_output_oe(pin_oe), .core_wrap_pulse(wrap_p),
        .aux_timer(aux_t), .core_timer(core_t),
        .capture_reload_reg(cap_r), .core_toggle_latch(latch),
        .capture_pulse(cap_p));
    // verdict, reached from the main sequence or the watchdog
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic cmp16(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : cmp16
    function automatic dtcr_tcfg_s mk(logic r, dtcr_src_e s,
        logic [2:0] p, logic [1:0] e, logic dp, logic d);
        return {r, s, p, e, dp, d};
    endfunction : mk
    // bounded wait for the core count to move, n = cycles taken
    task automatic wait_core(output int n);
        logic [15:0] p;
        p = core_t;
        n = 0;
        while (core_t === p && n < 600) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wait_core
    // down from zero wraps, then up from all ones wraps
    task automatic t_core_wrap;
        int n;
        cmp16("reset", 16'h0000, core_t | aux_t | cap_r);
        core_cfg = mk(1'b1, DTCR_SRC_PRE, 3'h0, 2'h0, 1'b0, 1'b1);
        wait_core(n);
        cmp16("core down", 16'hFFFF, core_t);
        cmp16("latch", 16'h0001, 16'(latch));
        cmp16("wrap pulse", 16'h0001, 16'(wrap_p));
        @(negedge clk_sys);
        cmp16("pulse ends", 16'h0000, 16'(wrap_p));
        core_cfg.down = 1'b0;
        wait_core(n);
        cmp16("core up", 16'h0000, core_t);
        cmp16("latch back", 16'h0000, 16'(latch));
        wait_core(n);
        cmp16("spacing", 16'h0002, 16'(n));
        core_cfg.pre = 3'h2;
        wait_core(n);
        wait_core(n);
        cmp16("prescale", 16'h0008, 16'(n));
    endtask : t_core_wrap
    // core reloads zero each tick, latch clocks aux
    task automatic t_chain;
        int k, w, z, n;
        logic lp;
        logic [15:0] a0;
        cap_cfg = {6'h00, 3'b011};
        core_cfg = mk(1'b1, DTCR_SRC_PRE, 3'h0, 2'h0, 1'b0, 1'b1);
        aux_cfg = mk(1'b1, DTCR_SRC_TGL, 3'h0, 2'h0, 1'b0, 1'b0);
        repeat (30) @(negedge clk_sys);
        lp = latch;
        for (n = 0; n < 9 && latch === lp; n++) @(negedge clk_sys);
        @(negedge clk_sys);
        a0 = aux_t;
        lp = latch;
        k = 0;
        w = 0;
        z = 0;
        repeat (40) begin
            @(negedge clk_sys);
            k += int'(latch !== lp);
            w += int'(wrap_p === 1'b1);
            z += int'(core_t !== 16'h0000);
            lp = latch;
        end
        @(negedge clk_sys);
        cmp16("flips", 16'h0014, 16'(k));
        cmp16("reloaded", 16'h0000, 16'(z));
        cmp16("pulses", 16'(k), 16'(w));
        cmp16("aux chain", a0 + 16'(k), aux_t);
        cmp16("pin enable", 16'h0001, 16'(pin_oe));
        cmp16("pin level", 16'(latch), 16'(pin_o));
    endtask : t_chain
    // external count edges, direction pin, clock enable freeze
    task automatic t_ext_dir;
        logic [15:0] a0;
        core_cfg.run = 1'b0;
        cap_cfg = '0;
        aux_cfg = mk(1'b1, DTCR_SRC_EXT, 3'h0, 2'b10, 1'b1, 1'b0);
        u_dtcr_pin_drv.flip(5);
        a0 = aux_t;
        repeat (6) u_dtcr_pin_drv.flip(6);
        cmp16("aux down", a0 - 16'h0003, aux_t);
        ce = 1'b0;
        repeat (2) u_dtcr_pin_drv.flip(6);
        ce = 1'b1;
        u_dtcr_pin_drv.flip(5);
        repeat (4) u_dtcr_pin_drv.flip(6);
        cmp16("aux up", a0 - 16'h0001, aux_t);
    endtask : t_ext_dir
    // rising edges on each capture source capture, falling do not
    task automatic t_capture;
        int c0;
        aux_cfg = mk(1'b1, DTCR_SRC_PRE, 3'h0, 2'h0, 1'b0, 1'b0);
        cap_cfg = {6'b10_1010, 3'b100};
        @(negedge clk_sys);
        cmp16("pin off", 16'h0000, 16'({pin_oe, pin_o}));
        for (int i = 0; i < 3; i++) begin
            c0 = caps;
            u_dtcr_pin_drv.flip(i);
            repeat (2) @(negedge clk_sys);
            cmp16("cap rise", 16'(c0 + 1), 16'(caps));
            u_dtcr_pin_drv.flip(i);
            repeat (2) @(negedge clk_sys);
            cmp16("cap fall", 16'(c0 + 1), 16'(caps));
        end
    endtask : t_capture
    initial begin
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        t_core_wrap();
        t_chain();
        t_ext_dir();
        t_capture();
        end_sim();
    end
    // watchdog, far beyond the few hundred cycles expected
    initial begin
        #100_000;
        miscompares++;
        end_sim();
    end
endmodule : dtcr_top_bench
`default_nettype wire
